// File: agpt_target.sv
// Graphics-port target with fast-write rate selection and crossing
`timescale 1ns/1ns
// Operation
// - Accept all memory reads/writes, both priorities
// - Never forward graphics cycles to hub
// - Pipelined and sideband accesses not snooped
// - Status rate field bit 2 reports 4X
// - Rate select bit 2 gives 4X transfers
// - 4X moves 16 bytes per bus clock
// - Throttle block stays four clocks, 64 bytes
// - 4X adds two data, one sideband strobe
// - Handshake identical at every rate
// - Capability enable resets 0, gates support flag
// - Fast write only when both enables set
// - Rate bits pick 4X, 2X or PCI
// - Frame accesses snooped on host bus
// - No lock or parity/system error pins
// - Frame reads claimed for memory only
// - Write posts memory; invalidate posts both
// - Other frame commands never claimed
// - Transactions kept in issue order
module agpt_target
  import agpt_pkg::*;
(
  input wire clk, // Core clock
  input wire sys_rst, // Asynchronous reset, high
  input wire link_clk, // Graphics bus clock
  input wire [2:0] data_rate_select, // Rate select bits
  input wire fast_write_capability_enable, // Capability enable
  input wire fast_write_command_enable, // Command enable
  input wire req_valid, // Link request strobe
  input wire agpt_req_s req, // Link request fields
  input wire req_last, // Last data clock of request
  input wire fw_req, // Core asks for a fast write
  output logic [2:0] port_status_rate_field, // Reported capabilities
  output logic fast_write_supported_flag, // Fast write reported
  output logic [1:0] fw_protocol, // Write protocol in use
  output logic [4:0] bytes_per_clock, // Bytes per bus clock
  output logic [2:0] ad_strobe_en, // Strobes in use
  output logic claim, // Link: request claimed
  output logic block_end, // Link: throttle point
  output logic snoop_pulse, // Core: snoop the host bus
  output logic mem_read, // Core: read request
  output logic mem_write, // Core: write request
  output logic high_prio, // Core: priority of request
  output logic [31:0] mem_addr, // Core: request address
  output logic busy // Core: request in flight
);

  // ---- Core clock domain: configuration and fast-write choice ----
  logic [2:0] rate_sync1;
  logic [2:0] rate_sync2;
  logic [2:0] rate_sync3;
  logic [2:0] rate;
  logic rate_locked;
  logic fwce_s1;
  logic fwce_s2;
  logic fwpe_s1;
  logic fwpe_s2;
  wire fw_on;
  wire rate_steady;
  wire [1:0] next_fw_protocol;
  wire [1:0] next_fw_latched;
  wire [4:0] next_bytes;
  wire [2:0] next_strobes;

  // Config pins are quasi-static but asynchronous; synchronise them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_sync1 <= 3'h0;
      rate_sync2 <= 3'h0;
      rate_sync3 <= 3'h0;
      fwce_s1 <= 1'b0;
      fwce_s2 <= 1'b0;
      fwpe_s1 <= 1'b0;
      fwpe_s2 <= 1'b0;
    end else begin
      rate_sync1 <= data_rate_select;
      rate_sync2 <= rate_sync1;
      rate_sync3 <= rate_sync2;
      fwce_s1 <= fast_write_capability_enable;
      fwce_s2 <= fwce_s1;
      fwpe_s1 <= fast_write_command_enable;
      fwpe_s2 <= fwpe_s1;
    end
  end

  // Two equal synced samples guard against bits landing on different edges
  assign rate_steady = (rate_sync2 == rate_sync3) && (rate_sync2 != 3'h0);

  // Rate is captured once; later changes are ignored since not dynamic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate <= RATE_RESET;
      rate_locked <= 1'b0;
    end else if (!rate_locked && rate_steady) begin
      rate <= rate_sync2;
      rate_locked <= 1'b1;
    end
  end

  assign fw_on = fwce_s2 && fwpe_s2;
  // Priority 4X, 2X, else PCI; guards against several bits set
  assign next_fw_protocol = !fw_on ? WP_1X :
      rate[RATE_4X_BIT] ? WP_4X :
      rate[RATE_2X_BIT] ? WP_2X : WP_1X;
  // Link data rate from the select; handshake unchanged
  assign next_bytes = rate[RATE_4X_BIT] ? BYTES_4X :
      rate[RATE_2X_BIT] ? BYTES_2X : BYTES_1X;
  assign next_strobes = rate[RATE_4X_BIT] ?
      3'(((1 << AD_STROBES_4X) - 1) |
         (((1 << SBA_STROBES_4X) - 1) << AD_STROBES_4X)) :
      3'h0;
  // New write protocol only when the core asks; held otherwise
  assign next_fw_latched = fw_req ? next_fw_protocol : fw_protocol;

  // Registered status and rate outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_status_rate_field <= 3'h0;
      fast_write_supported_flag <= 1'b0;
      fw_protocol <= WP_1X;
      bytes_per_clock <= BYTES_1X;
      ad_strobe_en <= 3'h0;
    end else begin
      port_status_rate_field <= RATE_CAPS;
      fast_write_supported_flag <= fwce_s2;
      fw_protocol <= next_fw_latched;
      bytes_per_clock <= next_bytes;
      ad_strobe_en <= next_strobes;
    end
  end

  // ---- Link clock domain: decode and claim ----
  agpt_dec_s dec;
  agpt_dec_s held;
  logic lrst_s1;
  logic lrst;
  logic [2:0] blk_cnt;
  logic req_tgl;
  logic ack_s1;
  logic ack_s2;
  logic ack_tgl; // Driven by the core side below
  logic link_pend;
  wire accept;
  wire [2:0] next_blk_cnt;
  wire [2:0] next_blk_val;
  wire next_block_end;

  agpt_decode u_dec (
    .req(req),
    .dec(dec)
  );

  // Reset release synchronised into the link domain
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lrst_s1 <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_s1 <= 1'b0;
      lrst <= lrst_s1;
    end
  end

  // One request in flight keeps issue order intact
  assign accept = req_valid && dec.claim && !link_pend;
  assign next_blk_cnt = (blk_cnt == BLOCK_CLOCKS - 3'h1) ? 3'h0 :
                        blk_cnt + 3'h1;
  // Count only inside a burst; the last data clock restarts the block
  assign next_blk_val = (req_valid && !req_last) ? next_blk_cnt : 3'h0;
  assign next_block_end = req_valid && (blk_cnt == BLOCK_CLOCKS - 3'h1);

  // Claim, held word and throttle counter
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      claim <= 1'b0;
      held <= '0;
      req_tgl <= 1'b0;
      blk_cnt <= 3'h0;
      block_end <= 1'b0;
    end else if (lrst) begin
      claim <= 1'b0;
      blk_cnt <= 3'h0;
      block_end <= 1'b0;
    end else begin
      claim <= accept;
      if (accept) begin
        held <= dec;
        req_tgl <= ~req_tgl;
      end
      // Throttle only on four-clock boundaries
      blk_cnt <= next_blk_val;
      block_end <= next_block_end;
    end
  end

  // Acknowledge toggle back from core, two flops
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end
  assign link_pend = (req_tgl != ack_s2);

  // ---- Core domain: toggle handshake receiver ----
  logic tg_s1;
  logic tg_s2;
  logic tg_s3;
  agpt_dec_s core_word;
  agpt_state_e state;
  agpt_state_e next_state;
  wire new_req;
  wire in_busy;
  wire next_snoop;
  wire next_read;
  wire next_write;
  wire next_prio;
  wire [31:0] next_addr;
  wire next_busy;

  // Request toggle from the link side, two flops plus an edge stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      tg_s1 <= req_tgl;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end
  assign new_req = tg_s2 ^ tg_s3;

  // Held word is stable while the toggle is outstanding
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (new_req) begin
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        next_state = ST_DONE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Copy the held word once; the link side reuses it only after the ack
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_word <= '0;
    end else if (new_req) begin
      core_word <= held;
    end
  end

  // Core pulses decoded from the copy while busy
  assign in_busy = (state == ST_BUSY);
  assign next_snoop = in_busy && core_word.snoop;
  assign next_read = in_busy && core_word.is_read;
  assign next_write = in_busy && core_word.is_write;
  assign next_prio = in_busy && core_word.high_prio;
  assign next_addr = in_busy ? core_word.addr : mem_addr;
  assign next_busy = (next_state != ST_IDLE);

  // State and registered core outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      ack_tgl <= 1'b0;
      snoop_pulse <= 1'b0;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      high_prio <= 1'b0;
      mem_addr <= ADDR_RESET;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      snoop_pulse <= next_snoop;
      mem_read <= next_read;
      mem_write <= next_write;
      high_prio <= next_prio;
      mem_addr <= next_addr;
      busy <= next_busy;
      if (state == ST_DONE) begin
        ack_tgl <= ~ack_tgl;
      end
    end
  end

  // No lock, parity or system error pins exist on this port

endmodule

// File: agpt_pkg.sv
// Shared constants and carriers for the graphics-port target block
package agpt_pkg;

  // Rate field bit positions
  localparam int RATE_1X_BIT = 0;
  localparam int RATE_2X_BIT = 1;
  localparam int RATE_4X_BIT = 2;
  localparam logic [2:0] RATE_CAPS = 3'h7;
  // Rate in force until the select is captured
  localparam logic [2:0] RATE_RESET = 3'h1;

  // Bytes moved per bus clock at each rate
  localparam logic [4:0] BYTES_1X = 5'h04;
  localparam logic [4:0] BYTES_2X = 5'h08;
  localparam logic [4:0] BYTES_4X = 5'h10;
  // Smallest throttleable block in bus clocks
  localparam logic [2:0] BLOCK_CLOCKS = 3'h4;
  // Extra complementary strobes at 4X
  localparam int AD_STROBES_4X = 2;
  localparam int SBA_STROBES_4X = 1;

  // Graphics-port command encodings
  localparam logic [3:0] GC_READ = 4'h0;
  localparam logic [3:0] GC_HP_READ = 4'h1;
  localparam logic [3:0] GC_WRITE = 4'h4;
  localparam logic [3:0] GC_HP_WRITE = 4'h5;
  localparam logic [3:0] GC_LONG_READ = 4'h8;
  localparam logic [3:0] GC_HP_LONG_READ = 4'h9;

  // Frame-based command encodings
  localparam logic [3:0] FC_INTACK = 4'h0;
  localparam logic [3:0] FC_SPECIAL = 4'h1;
  localparam logic [3:0] FC_IO_READ = 4'h2;
  localparam logic [3:0] FC_IO_WRITE = 4'h3;
  localparam logic [3:0] FC_MEM_READ = 4'h6;
  localparam logic [3:0] FC_MEM_WRITE = 4'h7;
  localparam logic [3:0] FC_CFG_READ = 4'ha;
  localparam logic [3:0] FC_CFG_WRITE = 4'hb;
  localparam logic [3:0] FC_MEM_READ_MUL = 4'hc;
  localparam logic [3:0] FC_DUAL_ADDR = 4'hd;
  localparam logic [3:0] FC_MEM_READ_LINE = 4'he;
  localparam logic [3:0] FC_MEM_WRITE_INV = 4'hf;

  // Protocol on which a request arrived
  localparam logic [1:0] PROTO_PIPE = 2'h0;
  localparam logic [1:0] PROTO_SBA = 2'h1;
  localparam logic [1:0] PROTO_FRAME = 2'h2;

  // Write protocol toward the graphics master
  localparam logic [1:0] WP_1X = 2'h0;
  localparam logic [1:0] WP_2X = 2'h1;
  localparam logic [1:0] WP_4X = 2'h2;

  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  // Request as seen at the link
  typedef struct packed {
    logic [1:0] proto;
    logic [3:0] cmd;
    logic to_memory;
    logic [31:0] addr;
  } agpt_req_s;

  // Decoded answer handed to the core side
  typedef struct packed {
    logic claim;
    logic is_read;
    logic is_write;
    logic high_prio;
    logic snoop;
    logic [31:0] addr;
  } agpt_dec_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } agpt_state_e;

endpackage

// File: agpt_decode.sv
// Link-side command decoder for graphics-port and frame-based requests
`timescale 1ns/1ns
module agpt_decode
  import agpt_pkg::*;
(
  input wire agpt_req_s req, // Request fields
  output agpt_dec_s dec // Decoded response
);

  wire is_frame;
  wire gp_read;
  wire gp_write;
  wire gp_hp;
  wire f_read;
  wire f_write;
  wire f_wri;

  assign is_frame = (req.proto == PROTO_FRAME);
  // Graphics-port commands, memory only; others get no response
  assign gp_read = (req.cmd == GC_READ) || (req.cmd == GC_HP_READ) ||
                   (req.cmd == GC_LONG_READ) ||
                   (req.cmd == GC_HP_LONG_READ);
  assign gp_write = (req.cmd == GC_WRITE) || (req.cmd == GC_HP_WRITE);
  assign gp_hp = (req.cmd == GC_HP_READ) || (req.cmd == GC_HP_WRITE) ||
                 (req.cmd == GC_HP_LONG_READ);
  // Frame reads alike for the three read commands
  assign f_read = (req.cmd == FC_MEM_READ) || (req.cmd == FC_MEM_READ_MUL) ||
                  (req.cmd == FC_MEM_READ_LINE);
  assign f_write = (req.cmd == FC_MEM_WRITE);
  assign f_wri = (req.cmd == FC_MEM_WRITE_INV);

  // Claim decision per protocol
  assign dec.claim = is_frame ?
      ((f_read && req.to_memory) ||
       (f_write && req.to_memory) || f_wri) :
      ((gp_read || gp_write) && req.to_memory);
  assign dec.is_read = is_frame ? f_read : gp_read;
  assign dec.is_write = is_frame ? (f_write || f_wri) : gp_write;
  assign dec.high_prio = !is_frame && gp_hp;
  // Only frame-based accesses are snooped
  assign dec.snoop = is_frame;
  assign dec.addr = req.addr;

endmodule

// File: agpt_checker.sv
// Port assertions for the graphics-port target
`timescale 1ns/1ns
module agpt_checker
  import agpt_pkg::*;
(
  input wire clk, // Core clock
  input wire sys_rst, // Async reset
  input wire link_clk, // Bus clock
  input wire req_valid, // Request valid
  input wire agpt_req_s req, // Request fields
  input wire req_last, // Last data clock
  input wire fw_req, // Fast write ask
  input wire [2:0] port_status_rate_field, // Caps
  input wire fast_write_supported_flag, // Support flag
  input wire [1:0] fw_protocol, // Write protocol
  input wire [4:0] bytes_per_clock, // Bytes per clock
  input wire [2:0] ad_strobe_en, // Strobes
  input wire claim, // Claimed
  input wire block_end, // Throttle point
  input wire mem_read, // Read pulse
  input wire mem_write, // Write pulse
  input wire high_prio // Priority
);
  // Link side: claims follow a request
  a_claim_after_valid: assert property (@(posedge link_clk)
    disable iff (sys_rst) claim |-> $past(req_valid))
    else $error("claim without request");
  a_hub_not_claimed: assert property (@(posedge link_clk)
    disable iff (sys_rst) claim |-> $past(req.to_memory) ||
    $past(req.cmd) == FC_MEM_WRITE_INV) else $error("hub request claimed");
  a_frame_cmd_set: assert property (@(posedge link_clk)
    disable iff (sys_rst) claim && $past(req.proto) == PROTO_FRAME |->
    $past(req.cmd) inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf})
    else $error("frame command wrongly claimed");
  // One in flight, so a claim never repeats at once
  a_claim_single: assert property (@(posedge link_clk)
    disable iff (sys_rst) claim |=> !claim) else $error("claim repeated");
  a_block_four: assert property (@(posedge link_clk)
    disable iff (sys_rst) block_end |-> $past(req_last) && $past(req_valid))
    else $error("throttle point off block");
  // Core side
  a_caps_report: assert property (@(posedge clk)
    disable iff (sys_rst)
    $past(!sys_rst) |-> port_status_rate_field == RATE_CAPS)
    else $error("capability field wrong");
  a_rate_strobes: assert property (@(posedge clk)
    disable iff (sys_rst)
    (bytes_per_clock == BYTES_4X) == (ad_strobe_en == 3'h7))
    else $error("strobes disagree with rate");
  a_fw_hold: assert property (@(posedge clk)
    disable iff (sys_rst) !fw_req |=> $stable(fw_protocol))
    else $error("write protocol moved");
  a_fw_needs_flag: assert property (@(posedge clk)
    disable iff (sys_rst) fw_protocol != WP_1X |-> fast_write_supported_flag)
    else $error("fast write without support");
  a_prio_with_op: assert property (@(posedge clk)
    disable iff (sys_rst) high_prio |-> mem_read || mem_write)
    else $error("priority without request");
  c_claim: cover property (@(posedge link_clk) claim);
  c_block: cover property (@(posedge link_clk) block_end);
  c_fw_4x: cover property (@(posedge clk) fw_protocol == WP_4X);
endmodule
bind agpt_target agpt_checker chk_i (.clk, .sys_rst, .link_clk, .req_valid,
  .req, .req_last, .fw_req, .port_status_rate_field,
  .fast_write_supported_flag, .fw_protocol, .bytes_per_clock, .ad_strobe_en,
  .claim, .block_end, .mem_read, .mem_write, .high_prio);

// File: agpt_gfx_master.sv
// Graphics master model issuing link requests
`timescale 1ns/1ns
module agpt_gfx_master
  import agpt_pkg::*;
(
  input wire link_clk, // Bus clock
  output logic req_valid, // Request valid
  output agpt_req_s req, // Request fields
  output logic req_last // Last data clock
);
  initial begin
    req_valid = 1'b0;
    req_last = 1'b0;
    req = '0;
  end
  // One four-clock block, same handshake at every rate
  task automatic issue(input agpt_req_s r);
    @(posedge link_clk);
    req <= r;
    req_valid <= 1'b1;
    repeat (3) @(posedge link_clk);
    req_last <= 1'b1;
    @(posedge link_clk);
    req_valid <= 1'b0;
    req_last <= 1'b0;
    req <= ~r; // Released fields must not look stale
  endtask
endmodule

// File: agpt_tb.sv
// Self-checking bench for the graphics-port target
`timescale 1ns/1ns
module testbench;
  import agpt_pkg::*;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] data_rate_select = 3'h4;
  logic fast_write_capability_enable = 1'b0;
  logic fast_write_command_enable = 1'b0;
  logic fw_req = 1'b0;
  logic req_valid, req_last, claim, block_end, snoop_pulse, busy;
  logic fast_write_supported_flag, mem_read, mem_write, high_prio;
  agpt_req_s req;
  logic [2:0] port_status_rate_field, ad_strobe_en;
  logic [1:0] fw_protocol;
  logic [4:0] bytes_per_clock;
  logic [31:0] mem_addr;
  logic [3:0] core_seen = 4'h0;
  logic link_seen = 1'b0;
  logic blk_seen = 1'b0;
  logic [2:0] rates [3] = '{3'h4, 3'h2, 3'h1};
  logic [2:0] strobes [3] = '{3'h7, 3'h0, 3'h0};
  logic [4:0] bytes [3] = '{BYTES_4X, BYTES_2X, BYTES_1X};
  logic [1:0] wps [3] = '{WP_4X, WP_2X, WP_1X};
  int fails = 0;
  int check_count = 0;

  agpt_target uut (.clk, .sys_rst, .link_clk, .data_rate_select,
    .fast_write_capability_enable, .fast_write_command_enable, .req_valid,
    .req, .req_last, .fw_req, .port_status_rate_field,
    .fast_write_supported_flag, .fw_protocol, .bytes_per_clock,
    .ad_strobe_en, .claim, .block_end, .snoop_pulse, .mem_read, .mem_write,
    .high_prio, .mem_addr, .busy);
  agpt_gfx_master gm (.link_clk, .req_valid, .req, .req_last);

  // Clocks; the 7 ns offset keeps link edges off core edges
  initial forever #25 clk = ~clk;
  initial begin
    #7;
    forever begin
      link_clk = 1'b1;
      #62;
      link_clk = 1'b0;
      #63;
    end
  end
  // Sticky records, since pulses last one cycle
  always @(posedge clk)
    core_seen <= core_seen | {snoop_pulse, high_prio, mem_write, mem_read};
  always @(posedge link_clk) link_seen <= link_seen | claim;
  always @(posedge link_clk) blk_seen <= blk_seen | block_end;

  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Rate is set once, one bit only, then reset releases
  task automatic do_reset(input logic [2:0] r);
    @(posedge clk);
    sys_rst <= 1'b1;
    data_rate_select <= r;
    fast_write_capability_enable <= 1'b0;
    fast_write_command_enable <= 1'b0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(negedge clk);
  endtask

  task automatic fw_try(input logic ce, input logic pe, input logic [1:0] e,
      input logic f);
    @(posedge clk);
    fast_write_capability_enable <= ce;
    fast_write_command_enable <= pe;
    repeat (4) @(posedge clk);
    fw_req <= 1'b1;
    @(posedge clk);
    fw_req <= 1'b0;
    repeat (2) @(negedge clk);
    chk("fw_protocol", e, fw_protocol);
    chk("fw flag", f, fast_write_supported_flag);
  endtask

  // Expected {claim, snoop, priority, write, read}
  function automatic logic [4:0] expect_of(logic [1:0] p, logic [3:0] c,
      logic m);
    logic rd, wr, ok, fr;
    fr = (p == PROTO_FRAME);
    rd = fr ? c inside {FC_MEM_READ, FC_MEM_READ_MUL, FC_MEM_READ_LINE}
      : c inside {GC_READ, GC_HP_READ, GC_LONG_READ, GC_HP_LONG_READ};
    wr = fr ? c inside {FC_MEM_WRITE, FC_MEM_WRITE_INV}
      : c inside {GC_WRITE, GC_HP_WRITE};
    ok = (rd || wr) && (m || (fr && c == FC_MEM_WRITE_INV));
    return {ok, ok && fr, ok && !fr && c[0], ok && wr, ok && rd};
  endfunction

  task automatic run_req(input logic [1:0] p, input logic [3:0] c,
      input logic m);
    agpt_req_s r;
    logic [4:0] e;
    r = '{p, c, m, {23'h0, p, c, m, 2'h0}};
    e = expect_of(p, c, m);
    @(negedge clk);
    core_seen = 4'h0;
    link_seen = 1'b0;
    blk_seen = 1'b0;
    gm.issue(r);
    repeat (16) @(posedge link_clk);
    @(negedge clk);
    chk("claim", e[4], link_seen);
    chk("core pulses", e[3:0], core_seen);
    chk("busy", 32'h0, busy);
    chk("block_end", 32'h1, blk_seen);
    if (e[4]) chk("mem_addr", r.addr, mem_addr);
  endtask

  initial begin
    for (int i = 0; i < 3; i++) begin
      do_reset(rates[i]);
      chk("rate field", RATE_CAPS, port_status_rate_field);
      chk("bytes", bytes[i], bytes_per_clock);
      chk("strobes", strobes[i], ad_strobe_en);
      fw_try(1'b0, 1'b1, WP_1X, 1'b0);
      fw_try(1'b1, 1'b0, WP_1X, 1'b1);
      fw_try(1'b1, 1'b1, wps[i], 1'b1);
    end
    $display("test rates done");
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 16; c++) begin
        for (int m = 0; m < 2; m++) begin
          run_req(2'(p), 4'(c), 1'(m));
        end
      end
    end
    $display("test requests done");
    stop_test;
  end

  // Watchdog well beyond the expected run of about 270 us
  initial begin
    #600000;
    fails++;
    stop_test;
  end
endmodule
